// [adc_scan_pkg.sv]
package adc_scan_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_RESULT_LOW = 6'h00;   // read: result low byte, write: software convert
	localparam logic [5:0] IDX_RESULT_HIGH_TAG = 6'h01; // read: result high nibble and channel tag
	localparam logic [5:0] IDX_RANGE_SETTING = 6'h02; // write: range code for scan start channel
	localparam logic [5:0] IDX_SCAN_START = 6'h04;   // write: scan start channel
	localparam logic [5:0] IDX_SCAN_STOP = 6'h05;    // write: scan stop channel
	localparam logic [5:0] IDX_CONTROL = 6'h06;      // write: control, read: control readback
	localparam logic [5:0] IDX_STATUS = 6'h07;       // read: fifo and interrupt status
	localparam logic [5:0] IDX_CLEAR_IRQ = 6'h08;    // write: clear pending interrupt
	localparam logic [5:0] IDX_CLEAR_FIFO = 6'h09;   // write: empty sample fifo

	// ----------------------------------------------------------------
	// control register field positions
	// ----------------------------------------------------------------
	localparam int CTL_SOFTWARE_TRIGGER_ENABLE = 0;
	localparam int CTL_PACER_TRIGGER_ENABLE = 1;
	localparam int CTL_OUTSIDE_TRIGGER_ENABLE = 2;
	localparam int CTL_GATE_ENABLE = 3;
	localparam int CTL_INTERRUPT_ENABLE_BIT = 4;
	localparam int CTL_INTERRUPT_SOURCE_SELECT = 5;
	localparam int CTL_FIRST_COUNTER_CLOCK_SELECT = 6;
	localparam logic [6:0] CTL_RESET = 7'h00;

	// ----------------------------------------------------------------
	// status register field positions
	// ----------------------------------------------------------------
	localparam int STS_FIFO_EMPTY = 0;
	localparam int STS_FIFO_HALF = 1;
	localparam int STS_FIFO_FULL = 2;
	localparam int STS_IRQ_PENDING = 3;

	// ----------------------------------------------------------------
	// field widths and sizes
	// ----------------------------------------------------------------
	localparam int RESULT_W = 12;                    // conversion result width
	localparam int CHAN_W = 4;                       // channel number width
	localparam int RANGE_W = 3;                      // range code width
	localparam int NUM_CHANNELS = 16;
	localparam int FIFO_AW = 10;                     // fifo address width
	localparam int FIFO_DEPTH = 1024;                // sample fifo entries
	localparam logic [FIFO_AW:0] FIFO_HALF_LEVEL = 11'h200;
	localparam logic [FIFO_AW:0] FIFO_FULL_LEVEL = 11'h400;
	localparam logic [CHAN_W-1:0] CHAN_RESET = 4'h0;

	// ----------------------------------------------------------------
	// range code decode: gain factor per code
	// ----------------------------------------------------------------
	localparam logic [RANGE_W-1:0] RANGE_GAIN_1 = 3'h0;  // +/-10 V
	localparam logic [RANGE_W-1:0] RANGE_GAIN_2 = 3'h1;  // +/-5 V
	localparam logic [RANGE_W-1:0] RANGE_GAIN_4 = 3'h2;  // +/-2.5 V
	localparam logic [RANGE_W-1:0] RANGE_GAIN_8 = 3'h3;  // +/-1.25 V
	localparam logic [RANGE_W-1:0] RANGE_GAIN_16 = 3'h4; // +/-0.625 V
	localparam logic [4:0] GAIN_FACTOR_1 = 5'h01;
	localparam logic [4:0] GAIN_FACTOR_2 = 5'h02;
	localparam logic [4:0] GAIN_FACTOR_4 = 5'h04;
	localparam logic [4:0] GAIN_FACTOR_8 = 5'h08;
	localparam logic [4:0] GAIN_FACTOR_16 = 5'h10;
	localparam logic [4:0] GAIN_FACTOR_NONE = 5'h00;     // undefined codes 5..7

endpackage

// [adc_scan_trigger_control.sv]
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps

// Functional notes
// - result low byte index 0, high nibble index 1
// - channel tag in bits 7..4 of index 1
// - trigger source chosen by control bits 2..0
// - software mode: any write index 0 converts
// - per-channel 3-bit range code in RAM
// - range code stored at start channel address
// - range codes 0..4 give gains 1..16
// - start/stop channel from writes, write-only
// - scan channel write restarts at start channel
// - each trigger advances multiplexer channel
// - scan start to stop, then repeat
// - start above stop wraps 15 to 0
// - control readback returns last written bits 6..0
// - status bits: empty, half full, full
// - status bit 3 shows interrupt pending
// - control bits enable software, pacer, outside trigger
// - control bit 3 gates outside triggers
// - bit 4 enables irq, per-conversion source
// - bit 5 set: irq on fifo half full
// - bit 6 selects counter 0 clock source
// - write index 8 clears irq, 9 fifo
// - pacer rising edge starts one conversion
module adc_scan_trigger_control (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pacer_out,
	input wire logic outside_trigger_in,
	input wire logic outside_gate_in,
	input wire logic adc_done,
	input wire logic [11:0] adc_data,
	output logic conv_start,
	output logic [3:0] mux_channel,
	output logic [2:0] range_code,
	output logic [4:0] gain_factor,
	output logic irq,
	output logic first_counter_clock_select
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [5:0] reg_idx;                  // word index of the access
	logic aligned;                        // low address bits are zero
	logic setup_phase;                    // apb setup cycle
	logic access_phase;                   // apb access cycle, always completes
	logic wr_access;                      // write takes effect now
	logic rd_access;                      // read completes now
	logic [6:0] control_reg;              // control register image
	logic [3:0] scan_start_reg;           // scan_first_channel_field
	logic [3:0] scan_stop_reg;            // channel_tag_or_stop_field
	logic [3:0] mux_ptr_reg;              // channel selected for next conversion
	logic [3:0] tag_reg;                  // channel of conversion in flight
	logic [2:0] range_ram [0:15];         // range_code_field per channel
	logic [2:0] pin_meta_reg;             // first sync stage, read only by stage two
	logic [2:0] pin_sync_reg;             // second sync stage
	logic [2:0] pin_prev_reg;             // for edge detection
	logic pacer_rise;
	logic outside_rise;
	logic trigger;                        // one conversion trigger this cycle
	logic [15:0] fifo_mem [0:1023];       // {tag, result} entries
	logic [9:0] wr_ptr_reg;
	logic [9:0] rd_ptr_reg;
	logic [10:0] count_reg;
	logic fifo_push;
	logic fifo_pop;
	logic fifo_empty;
	logic fifo_half;
	logic fifo_full;
	logic half_prev_reg;                  // half-full level one cycle ago
	logic irq_pending_reg;
	logic irq_event;
	logic [15:0] head_word;
	logic [31:0] rdata_next;
	logic mapped;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	assign reg_idx = paddr[7:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign setup_phase = psel & ~penable;
	assign access_phase = psel & penable;
	assign wr_access = access_phase & pwrite & aligned;
	assign rd_access = access_phase & ~pwrite & aligned;

	// known offsets; holes and misaligned addresses answer with an error
	always_comb begin
		unique case (reg_idx)
			adc_scan_pkg::IDX_RESULT_LOW,
			adc_scan_pkg::IDX_RESULT_HIGH_TAG,
			adc_scan_pkg::IDX_RANGE_SETTING,
			adc_scan_pkg::IDX_SCAN_START,
			adc_scan_pkg::IDX_SCAN_STOP,
			adc_scan_pkg::IDX_CONTROL,
			adc_scan_pkg::IDX_STATUS,
			adc_scan_pkg::IDX_CLEAR_IRQ,
			adc_scan_pkg::IDX_CLEAR_FIFO: mapped = aligned;
			default: mapped = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// control register and scan range
	// ----------------------------------------------------------------
	// control image; bit 7 is not stored and reads zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_reg <= adc_scan_pkg::CTL_RESET;
		end else if (wr_access && reg_idx == adc_scan_pkg::IDX_CONTROL) begin
			control_reg <= pwdata[6:0];
		end
	end

	// start and stop channel, low nibble only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_start_reg <= adc_scan_pkg::CHAN_RESET;
			scan_stop_reg <= adc_scan_pkg::CHAN_RESET;
		end else if (wr_access) begin
			if (reg_idx == adc_scan_pkg::IDX_SCAN_START) begin
				scan_start_reg <= pwdata[3:0];
			end
			if (reg_idx == adc_scan_pkg::IDX_SCAN_STOP) begin
				scan_stop_reg <= pwdata[3:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisers: pacer, outside trigger, outside gate
	// ----------------------------------------------------------------
	// two stages before any logic; a third holds the previous level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_reg <= 3'h0;
			pin_sync_reg <= 3'h0;
			pin_prev_reg <= 3'h0;
		end else begin
			pin_meta_reg <= {outside_gate_in, outside_trigger_in, pacer_out};
			pin_sync_reg <= pin_meta_reg;
			pin_prev_reg <= pin_sync_reg;
		end
	end

	assign pacer_rise = pin_sync_reg[0] & ~pin_prev_reg[0];
	assign outside_rise = pin_sync_reg[1] & ~pin_prev_reg[1];

	// ----------------------------------------------------------------
	// trigger selection
	// ----------------------------------------------------------------
	// each source counts only while its enable is set; with more than one
	// enable set the sources simply merge, which software must avoid
	always_comb begin
		trigger = 1'b0;
		if (control_reg[adc_scan_pkg::CTL_SOFTWARE_TRIGGER_ENABLE] && wr_access
			&& reg_idx == adc_scan_pkg::IDX_RESULT_LOW) begin
			trigger = 1'b1;
		end
		if (control_reg[adc_scan_pkg::CTL_PACER_TRIGGER_ENABLE] && pacer_rise) begin
			trigger = 1'b1;
		end
		if (control_reg[adc_scan_pkg::CTL_OUTSIDE_TRIGGER_ENABLE] && outside_rise
			&& (!control_reg[adc_scan_pkg::CTL_GATE_ENABLE] || pin_sync_reg[2])) begin
			trigger = 1'b1;
		end
	end

	// conversion start pulse, one cycle per trigger
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_start <= 1'b0;
		end else begin
			conv_start <= trigger;
		end
	end

	// ----------------------------------------------------------------
	// scan pointer
	// ----------------------------------------------------------------
	// a scan register write wins over a trigger in the same cycle, so the
	// pointer lands on the start channel; that trigger still converts the old one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mux_ptr_reg <= adc_scan_pkg::CHAN_RESET;
		end else if (wr_access && reg_idx == adc_scan_pkg::IDX_SCAN_START) begin
			mux_ptr_reg <= pwdata[3:0];
		end else if (wr_access && reg_idx == adc_scan_pkg::IDX_SCAN_STOP) begin
			mux_ptr_reg <= scan_start_reg;
		end else if (trigger) begin
			if (mux_ptr_reg == scan_stop_reg) begin
				mux_ptr_reg <= scan_start_reg;
			end else begin
				mux_ptr_reg <= mux_ptr_reg + 4'h1;
			end
		end
	end

	// channel under conversion, used as the tag of its result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tag_reg <= adc_scan_pkg::CHAN_RESET;
		end else if (trigger) begin
			tag_reg <= mux_ptr_reg;
		end
	end

	// multiplexer select follows the pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mux_channel <= adc_scan_pkg::CHAN_RESET;
		end else begin
			mux_channel <= mux_ptr_reg;
		end
	end

	// ----------------------------------------------------------------
	// range code ram
	// ----------------------------------------------------------------
	// addressed by the start field, not the live pointer; a running scan
	// does not move the write address but software should still stop it
	always_ff @(posedge pclk) begin
		if (wr_access && reg_idx == adc_scan_pkg::IDX_RANGE_SETTING) begin
			range_ram[scan_start_reg] <= pwdata[2:0];
		end
	end

	// range of the channel now selected; ram is not reset, so after reset the output
	// is unknown until a range code has been written for the selected channel
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			range_code <= adc_scan_pkg::RANGE_GAIN_1;
		end else begin
			range_code <= range_ram[mux_ptr_reg];
		end
	end

	// gain decode of the selected channel's code
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_factor <= adc_scan_pkg::GAIN_FACTOR_1;
		end else begin
			unique case (range_ram[mux_ptr_reg])
				adc_scan_pkg::RANGE_GAIN_1: gain_factor <= adc_scan_pkg::GAIN_FACTOR_1;
				adc_scan_pkg::RANGE_GAIN_2: gain_factor <= adc_scan_pkg::GAIN_FACTOR_2;
				adc_scan_pkg::RANGE_GAIN_4: gain_factor <= adc_scan_pkg::GAIN_FACTOR_4;
				adc_scan_pkg::RANGE_GAIN_8: gain_factor <= adc_scan_pkg::GAIN_FACTOR_8;
				adc_scan_pkg::RANGE_GAIN_16: gain_factor <= adc_scan_pkg::GAIN_FACTOR_16;
				default: gain_factor <= adc_scan_pkg::GAIN_FACTOR_NONE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// sample fifo
	// ----------------------------------------------------------------
	assign fifo_empty = (count_reg == 11'h000);
	assign fifo_full = (count_reg == adc_scan_pkg::FIFO_FULL_LEVEL);
	assign fifo_half = (count_reg >= adc_scan_pkg::FIFO_HALF_LEVEL);
	// a result arriving while full is dropped: the converter cannot stall
	assign fifo_push = adc_done & ~fifo_full;
	// reading the high byte retires the entry
	assign fifo_pop = rd_access & (reg_idx == adc_scan_pkg::IDX_RESULT_HIGH_TAG) & ~fifo_empty;
	assign head_word = fifo_mem[rd_ptr_reg];

	// storage, written only
	always_ff @(posedge pclk) begin
		if (fifo_push) begin
			fifo_mem[wr_ptr_reg] <= {tag_reg, adc_data};
		end
	end

	// pointers and level; clear empties the fifo and beats a push or pop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_reg <= 10'h000;
			rd_ptr_reg <= 10'h000;
			count_reg <= 11'h000;
		end else if (wr_access && reg_idx == adc_scan_pkg::IDX_CLEAR_FIFO) begin
			wr_ptr_reg <= 10'h000;
			rd_ptr_reg <= 10'h000;
			count_reg <= 11'h000;
		end else begin
			if (fifo_push) begin
				wr_ptr_reg <= wr_ptr_reg + 10'h001;
			end
			if (fifo_pop) begin
				rd_ptr_reg <= rd_ptr_reg + 10'h001;
			end
			if (fifo_push && !fifo_pop) begin
				count_reg <= count_reg + 11'h001;
			end else if (fifo_pop && !fifo_push) begin
				count_reg <= count_reg - 11'h001;
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_prev_reg <= 1'b0;
		end else begin
			half_prev_reg <= fifo_half;
		end
	end

	// source: each conversion, or the fifo crossing into half full
	always_comb begin
		if (control_reg[adc_scan_pkg::CTL_INTERRUPT_SOURCE_SELECT]) begin
			irq_event = fifo_half & ~half_prev_reg;
		end else begin
			irq_event = adc_done;
		end
	end

	// pending flag; an event in the clearing cycle keeps it set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pending_reg <= 1'b0;
		end else if (irq_event && control_reg[adc_scan_pkg::CTL_INTERRUPT_ENABLE_BIT]) begin
			irq_pending_reg <= 1'b1;
		end else if (wr_access && reg_idx == adc_scan_pkg::IDX_CLEAR_IRQ) begin
			irq_pending_reg <= 1'b0;
		end
	end

	// interrupt line and counter 0 clock select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
			first_counter_clock_select <= 1'b0;
		end else begin
			irq <= irq_pending_reg;
			first_counter_clock_select <= control_reg[adc_scan_pkg::CTL_FIRST_COUNTER_CLOCK_SELECT];
		end
	end

	// ----------------------------------------------------------------
	// read data and bus answer
	// ----------------------------------------------------------------
	// read mux, sampled in the setup cycle so prdata is a flop
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (aligned) begin
			unique case (reg_idx)
				adc_scan_pkg::IDX_RESULT_LOW: rdata_next = {24'h000000, head_word[7:0]};
				adc_scan_pkg::IDX_RESULT_HIGH_TAG: rdata_next = {24'h000000, head_word[15:8]};
				adc_scan_pkg::IDX_CONTROL: rdata_next = {25'h0000000, control_reg};
				adc_scan_pkg::IDX_STATUS: begin
					rdata_next[adc_scan_pkg::STS_FIFO_EMPTY] = fifo_empty;
					rdata_next[adc_scan_pkg::STS_FIFO_HALF] = fifo_half;
					rdata_next[adc_scan_pkg::STS_FIFO_FULL] = fifo_full;
					rdata_next[adc_scan_pkg::STS_IRQ_PENDING] = irq_pending_reg;
				end
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	// zero-wait answer: pready stands high from the first edge after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup_phase) begin
				prdata <= pwrite ? 32'h0000_0000 : rdata_next;
				pslverr <= ~mapped;
			end
		end
	end

endmodule // adc_scan_trigger_control

// [adc_scan_trigger_control_asserts.sv]
`timescale 1ns/1ps
module adc_scan_trigger_control_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pacer_out,
	input wire logic outside_trigger_in,
	input wire logic outside_gate_in,
	input wire logic adc_done,
	input wire logic [11:0] adc_data,
	input wire logic conv_start,
	input wire logic [3:0] mux_channel,
	input wire logic [2:0] range_code,
	input wire logic [4:0] gain_factor,
	input wire logic irq,
	input wire logic first_counter_clock_select
);
	// ------------------------------------------------
	// shadow of the host-visible settings
	// ------------------------------------------------
	logic wr_done; // write takes effect at this edge
	logic rd_done; // read data taken at this edge
	logic [6:0] ctl_q; // control as last written
	logic [3:0] start_q; // scan start channel
	logic [3:0] stop_q; // scan stop channel
	assign wr_done = psel & penable & pwrite & pready;
	assign rd_done = psel & penable & !pwrite & pready;
	// shadows move only on accepted writes, as the block does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= 7'h00;
			start_q <= 4'h0;
			stop_q <= 4'h0;
		end else if (wr_done) begin
			if (paddr == 8'h18) ctl_q <= pwdata[6:0];
			if (paddr == 8'h10) start_q <= pwdata[3:0];
			if (paddr == 8'h14) stop_q <= pwdata[3:0];
		end
	end
	// next channel of the scan, wrapping at stop or past 15
	function automatic logic [3:0] step(input logic [3:0] c);
		return (c == stop_q) ? start_q : c + 4'h1;
	endfunction
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------------------------------------------------
	// properties
	// ------------------------------------------------
	chk_soft_start: assert property (
		wr_done && paddr == 8'h00 && ctl_q[0] |=> conv_start) else $error("software write gave no start");
	chk_start_cause: assert property (
		conv_start |-> $past(ctl_q[2:0]) != 3'h0) else $error("start with all triggers off");
	chk_clock_select: assert property (
		first_counter_clock_select == $past(ctl_q[6])) else $error("clock select differs");
	chk_ctl_read: assert property (
		rd_done && paddr == 8'h18 |-> prdata == {25'h0, ctl_q}) else $error("control readback wrong");
	chk_irq_clear: assert property (
		wr_done && paddr == 8'h20 && !adc_done |=> ##1 !irq) else $error("interrupt not cleared");
	chk_irq_each: assert property (
		ctl_q[4] && !ctl_q[5] && adc_done |=> ##1 irq) else $error("no interrupt on conversion");
	chk_scan_step: assert property (
		conv_start |=> mux_channel == step($past(mux_channel))) else $error("scan step wrong");
	chk_scan_restart: assert property (
		wr_done && (paddr == 8'h10 || paddr == 8'h14) |-> ##2 mux_channel == start_q)
		else $error("scan not restarted");
	chk_unmapped_err: assert property (
		psel && !penable && paddr == 8'h0C |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
	cover property (conv_start && ctl_q[1]);
	cover property (wr_done && paddr == 8'h20);
	cover property (irq && ctl_q[5]);
endmodule // adc_scan_trigger_control_asserts

// [adc_conv_model.sv]
`timescale 1ns/1ps
module adc_conv_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic conv_start,
	input wire logic slow, // stretch the conversion time
	input wire logic [11:0] analog_val, // level to be converted
	output logic adc_done,
	output logic [11:0] adc_data
);
	logic [3:0] wait_q; // cycles left in conversion
	logic [11:0] held_q; // level latched at start
	// conversion timer, restarted by every start pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= 4'h0;
			held_q <= 12'h000;
			adc_done <= 1'b0;
		end else begin
			adc_done <= (wait_q == 4'h1);
			if (conv_start) begin
				wait_q <= slow ? 4'hC : 4'h2;
				held_q <= analog_val;
			end else if (wait_q != 4'h0) begin
				wait_q <= wait_q - 4'h1;
			end
		end
	end
	// data valid only with done; the inverse elsewhere exposes a stale capture
	assign adc_data = adc_done ? held_q : ~held_q;
endmodule // adc_conv_model

// [adc_scan_trigger_control_tb.sv]
`timescale 1ns/1ps
module adc_scan_trigger_control_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slow;
	logic pacer_out, outside_trigger_in, outside_gate_in, adc_done, conv_start;
	logic first_counter_clock_select;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_q, r;
	logic [11:0] adc_data, analog_val;
	logic [3:0] mux_channel, s, e, c;
	logic [2:0] range_code;
	logic [4:0] gain_factor;
	logic err_q;
	int fails, tests_run, starts, n0;
	adc_scan_trigger_control i_adc_scan_trigger_control (.*);
	adc_conv_model i_adc_conv_model (.*);
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// count start pulses to judge gating
	always @(posedge pclk) if (conv_start === 1'b1) starts++;
	// ------------------------------------------------
	// shared tasks
	// ------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
			fails++;
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// one apb transfer; idle edge after so no signal is set twice at once
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// software conversion, then read the entry back and compare
	task automatic conv(input logic [11:0] v, input logic [3:0] ch);
		int n;
		logic [7:0] lo;
		analog_val <= v;
		slow <= 1'($urandom);
		apb(1'b1, 6'h00, $urandom);
		n = 0;
		while (adc_done !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		repeat (2) @(posedge pclk);
		apb(1'b0, 6'h00, 32'h0);
		lo = rd_q[7:0];
		apb(1'b0, 6'h01, 32'h0);
		check("result low", 32'(lo), 32'(v[7:0]));
		check("result high tag", rd_q, {24'h0, ch, v[11:8]});
	endtask
	function automatic logic [3:0] nxt(input logic [3:0] x, input logic [3:0] a, input logic [3:0] b);
		return (x == b) ? a : x + 4'h1;
	endfunction
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, pacer_out, outside_trigger_in, outside_gate_in, slow} = 8'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		analog_val = 12'h000;
		fails = 0;
		tests_run = 0;
		starts = 0;
		r = $urandom(87);
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 6'h06, 32'h0);
		check("control at reset", rd_q, 32'h0);
		check("ready after reset", 32'(pready), 32'h1);
		apb(1'b0, 6'h07, 32'h0);
		check("status at reset", rd_q, 32'h1);
		check("pointer at reset", 32'(mux_channel), 32'h0);
		apb(1'b0, 6'h03, 32'h0);
		check("unmapped error", 32'(err_q), 32'h1);
		// control readback, trigger bits left off so one source at most is set
		repeat (4) begin
			r = $urandom & 32'hF8;
			apb(1'b1, 6'h06, r);
			apb(1'b0, 6'h06, 32'h0);
			check("control readback", rd_q, r & 32'h7F);
			check("counter clock select", 32'(first_counter_clock_select), 32'(r[6]));
		end
		// range codes: triggers off, start equals stop first
		apb(1'b1, 6'h06, 32'h0);
		// codes 5..7 are stored but decode to no gain
		for (int g = 0; g < 8; g++) begin
			c = 4'($urandom);
			apb(1'b1, 6'h04, 32'(c));
			apb(1'b1, 6'h05, 32'(c));
			apb(1'b1, 6'h02, 32'(g) | 32'hF8);
			repeat (2) @(posedge pclk);
			check("range code", 32'(range_code), 32'(g));
			check("gain", 32'(gain_factor), (g < 5) ? (32'h1 << g) : 32'h0);
		end
		// scan sequences: plain, wrapping, random
		apb(1'b1, 6'h06, 32'h01);
		for (int p = 0; p < 3; p++) begin
			s = (p == 0) ? 4'h3 : (p == 1) ? 4'hD : 4'($urandom);
			e = (p == 0) ? 4'h7 : (p == 1) ? 4'h2 : 4'($urandom);
			apb(1'b1, 6'h04, 32'(s));
			apb(1'b1, 6'h05, 32'(e));
			@(posedge pclk);
			check("scan restart", 32'(mux_channel), 32'(s));
			c = s;
			repeat (9) begin
				conv(12'($urandom), c);
				c = nxt(c, s, e);
			end
		end
		// interrupt on each conversion, then clear
		apb(1'b1, 6'h06, 32'h11);
		conv(12'hFFF, c);
		c = nxt(c, s, e);
		apb(1'b0, 6'h07, 32'h0);
		check("status pending", rd_q, 32'h9);
		check("irq line", 32'(irq), 32'h1);
		apb(1'b1, 6'h08, $urandom);
		apb(1'b0, 6'h07, 32'h0);
		check("status cleared", rd_q, 32'h1);
		// outside trigger, gated; then pacer
		apb(1'b1, 6'h06, 32'h0C);
		for (int k = 0; k < 2; k++) begin
			n0 = starts;
			outside_trigger_in <= 1'b1;
			repeat (6) @(posedge pclk);
			outside_trigger_in <= 1'b0;
			repeat (6) @(posedge pclk);
			check("gated starts", 32'(starts - n0), 32'(k));
			outside_gate_in <= 1'b1;
			repeat (3) @(posedge pclk);
		end
		apb(1'b1, 6'h06, 32'h02);
		n0 = starts;
		repeat (2) begin
			pacer_out <= 1'b1;
			repeat (6) @(posedge pclk);
			pacer_out <= 1'b0;
			repeat (6) @(posedge pclk);
		end
		check("pacer starts", 32'(starts - n0), 32'h2);
		// fill to half and full with interrupt on half
		// a slow paced conversion may still be running; let it land before the clear
		repeat (16) @(posedge pclk);
		apb(1'b1, 6'h09, 32'h0);
		apb(1'b1, 6'h06, 32'h31);
		slow <= 1'b0;
		for (int k = 1; k <= 1024; k++) begin
			apb(1'b1, 6'h00, 32'h0);
			if (k == 511 || k == 512 || k == 1024) begin
				repeat (4) @(posedge pclk);
				apb(1'b0, 6'h07, 32'h0);
				check("fill status", rd_q, (k == 511) ? 32'h0 : (k == 512) ? 32'hA : 32'hE);
			end
		end
		apb(1'b1, 6'h09, $urandom);
		apb(1'b0, 6'h07, 32'h0);
		check("fifo emptied", rd_q, 32'h9);
		// reset in mid-run clears enables, pointer and pending flag
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 6'h06, 32'h0);
		check("control after reset", rd_q, 32'h0);
		check("pointer after reset", 32'(mux_channel), 32'h0);
		apb(1'b0, 6'h07, 32'h0);
		check("status after reset", rd_q, 32'h1);
		close_out;
	end
	// cut a hang short
	initial begin
		#1000000;
		fails++;
		close_out;
	end
endmodule // adc_scan_trigger_control_tb
bind adc_scan_trigger_control adc_scan_trigger_control_asserts i_adc_scan_trigger_control_asserts (.*);
